/* inc/e1ts_cfg.svh */
`ifndef E1TS_CFG_SVH
`define E1TS_CFG_SVH
// ==========================================
// Time slot zero layout and timing
`define E1TS_CLK_NS 40
`define E1TS_FRAME_NS 125000
`define E1TS_FRAME_CYC ((`E1TS_FRAME_NS + `E1TS_CLK_NS - 1) / `E1TS_CLK_NS)
`define E1TS_FAS_PAT 7'h1B
`define E1TS_MFAS_PAT 6'h0B
`define E1TS_ALL_ONES 8'hFF
`define E1TS_NBYTES 5
`define E1TS_BUF_RST 8'hFF
`define E1TS_NFAS_BIT2 6
`define E1TS_CRC_BIT 7
`endif

/* inc/e1ts_pkg.sv */
package e1ts_pkg;
	// ==========================================
	// Types
	typedef enum logic [1:0] {
		E1TS_PARALLEL,
		E1TS_SERIAL_CTRL,
		E1TS_BACKPLANE
	} e1ts_port_mode_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic       rx_sel;
		logic [2:0] addr;
		logic [7:0] wdata;
	} e1ts_cpu_req_t;
endpackage : e1ts_pkg

/* hw/e1ts_top.sv */
`timescale 1ns/1ns
`include "e1ts_cfg.svh"
// Notes on behaviour
// - Force-all-ones pin low sends all ones from power-up, no register write.
// - Even frames carry the alignment word, odd frames the non-alignment word.
// - Bit 1 is MSB, bit 8 LSB, for line order and buffers.
// - Alignment word: CRC bit in position 1, then 0011011.
// - Non-alignment word: position 2 one, alarm at 3, Sa4..Sa8 at 4..8.
// - Odd frames 1..11 carry 001011 in position 1; frames 13, 15 carry E-bits.
// - C1..C4 in position 1 of frames 0,2,4,6 and again 8,10,12,14.
// - Five-byte tx and rx buffers; byte n is Sa(4+n), columns F1..F15.
// - Buffers reachable in parallel or serial modes, never in backplane mode.
// - Backplane mode: spare bits from control stream in, received to status out.
// - Link active: selected spare bit comes from link input, not the buffer.
// - Multiframe-start flag and maskable interrupt at each received multiframe.
// - 4 kbit/s link, one bit per non-alignment word on the chosen spare bit.
// - 4 kHz link clock output, aligned with received link data.
// - Link clock keeps phase across slips; link data may drop or repeat.
// - Link input sampled on rising internal 4 kHz edge; controller holds it.
// - Internal sampling clock is the inverse of the output link clock.
module e1ts_top #(
	parameter int FRAME_CYC = `E1TS_FRAME_CYC,
	parameter int NBYTES    = `E1TS_NBYTES
) (
	input  wire logic                     CORE_CLK,
	input  wire logic                     RST_B,
	input  wire logic                     FORCE_ALL_ONES_PIN_B,
	input  e1ts_pkg::e1ts_port_mode_t     PORT_MODE,
	input  e1ts_pkg::e1ts_cpu_req_t       CPU_REQ,
	output logic [7:0]                    CPU_RDATA,
	input  wire logic [3:0]               TX_CRC,
	input  wire logic [1:0]               TX_EBIT,
	input  wire logic                     REMOTE_ALARM_BIT,
	input  wire logic [7:0]               CONTROL_STREAM_IN_ZERO,
	output logic [7:0]                    TX_TS0,
	output logic                          TX_TS0_VLD,
	output logic                          TX_ALL_ONES,
	input  wire logic                     RX_TS0_STB,
	input  wire logic [7:0]               RX_TS0,
	input  wire logic [3:0]               RX_FRM_NUM,
	output logic [7:0]                    STATUS_STREAM_OUT,
	input  wire logic                     MF_FLAG_CLR,
	input  wire logic                     MF_IRQ_MASK,
	output logic                          MULTIFRAME_START_FLAG,
	output logic                          MULTIFRAME_START_IRQ,
	input  wire logic                     LINK_EN,
	input  wire logic [4:0]               LINK_SEL,
	input  wire logic                     LINK_TX_IN,
	output logic                          LINK_RX_OUT,
	output logic                          LINK_CLOCK_OUT
);
	// ==========================================
	// Helpers
	function automatic logic [2:0] col_of(input logic [3:0] frm);
		col_of = 3'h7 - frm[3:1];
	endfunction : col_of

	function automatic logic pick_sa(input logic [7:0] ts0, input logic [4:0] sel);
		pick_sa = |(ts0[4:0] & {sel[0], sel[1], sel[2], sel[3], sel[4]});
	endfunction : pick_sa

	localparam logic [11:0] FRAME_LAST = 12'(FRAME_CYC - 1);
	localparam logic [5:0]  MFAS_PAT   = `E1TS_MFAS_PAT;

	// ==========================================
	// Frame divider and link clocks
	logic [11:0] div_q;
	logic [11:0] div_d;
	logic [3:0]  tx_frm_q;
	logic [3:0]  tx_frm_d;
	logic        link_clk_q;
	logic        link_clk_d;
	logic        tick;
	logic        link_rise;
	logic        sample_rise;

	always_comb begin
		tick       = (div_q == FRAME_LAST);
		div_d      = tick ? 12'h000 : div_q + 12'h001;
		tx_frm_d   = tick ? tx_frm_q + 4'h1 : tx_frm_q;
		// Free running from the core clock, so a receive slip never moves it
		link_clk_d = tick ? ~link_clk_q : link_clk_q;
		link_rise  = tick & ~link_clk_q;
		sample_rise = tick & link_clk_q;
	end

	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			div_q      <= 12'h000;
			tx_frm_q   <= 4'h0;
			link_clk_q <= 1'b0;
		end else begin
			div_q      <= div_d;
			tx_frm_q   <= tx_frm_d;
			link_clk_q <= link_clk_d;
		end
	end

	assign LINK_CLOCK_OUT = link_clk_q;

	// ==========================================
	// Buffers, register port and link data
	logic [7:0] tx_buf_q [NBYTES];
	logic [7:0] tx_buf_d [NBYTES];
	logic [7:0] rx_buf_q [NBYTES];
	logic [7:0] rx_buf_d [NBYTES];
	logic [7:0] stage_q  [NBYTES];
	logic [7:0] stage_d  [NBYTES];
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic [7:0] status_q;
	logic [7:0] status_d;
	logic       flag_q;
	logic       flag_d;
	logic       link_tx_q;
	logic       link_tx_d;
	logic       link_rxb_q;
	logic       link_rxb_d;
	logic       link_out_q;
	logic       link_out_d;
	logic       cpu_ok;
	logic       addr_ok;
	logic       rx_odd;
	logic       mf_start;

	always_comb begin
		cpu_ok   = (PORT_MODE != e1ts_pkg::E1TS_BACKPLANE);
		addr_ok  = (int'(CPU_REQ.addr) < NBYTES);
		rx_odd   = RX_TS0_STB & RX_FRM_NUM[0];
		mf_start = RX_TS0_STB & (RX_FRM_NUM == 4'h0);
		tx_buf_d = tx_buf_q;
		rx_buf_d = rx_buf_q;
		stage_d  = stage_q;
		rdata_d  = rdata_q;
		status_d = status_q;
		if (cpu_ok && addr_ok && CPU_REQ.wr && !CPU_REQ.rx_sel) begin
			tx_buf_d[CPU_REQ.addr] = CPU_REQ.wdata;
		end
		if (CPU_REQ.rd) begin
			if (!cpu_ok || !addr_ok) begin
				rdata_d = 8'h00;
			end else if (CPU_REQ.rx_sel) begin
				rdata_d = rx_buf_q[CPU_REQ.addr];
			end else begin
				rdata_d = tx_buf_q[CPU_REQ.addr];
			end
		end
		if (rx_odd) begin
			for (int s = 0; s < NBYTES; s++) begin
				stage_d[s][col_of(RX_FRM_NUM)] = RX_TS0[4 - s];
			end
			status_d = RX_TS0;
		end
		if (mf_start) begin
			rx_buf_d = stage_q;
		end
		// A new multiframe start beats a clear in the same cycle
		flag_d = mf_start | (flag_q & ~MF_FLAG_CLR);
		link_tx_d  = sample_rise ? LINK_TX_IN : link_tx_q;
		link_rxb_d = (rx_odd && LINK_EN) ? pick_sa(RX_TS0, LINK_SEL) : link_rxb_q;
		link_out_d = link_rise ? link_rxb_q : link_out_q;
	end

	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			for (int s = 0; s < NBYTES; s++) begin
				tx_buf_q[s] <= `E1TS_BUF_RST;
				rx_buf_q[s] <= `E1TS_BUF_RST;
				stage_q[s]  <= `E1TS_BUF_RST;
			end
			rdata_q    <= 8'h00;
			status_q   <= 8'h00;
			flag_q     <= 1'b0;
			link_tx_q  <= 1'b1;
			link_rxb_q <= 1'b1;
			link_out_q <= 1'b1;
		end else begin
			tx_buf_q   <= tx_buf_d;
			rx_buf_q   <= rx_buf_d;
			stage_q    <= stage_d;
			rdata_q    <= rdata_d;
			status_q   <= status_d;
			flag_q     <= flag_d;
			link_tx_q  <= link_tx_d;
			link_rxb_q <= link_rxb_d;
			link_out_q <= link_out_d;
		end
	end

	assign CPU_RDATA             = rdata_q;
	assign STATUS_STREAM_OUT     = status_q;
	assign MULTIFRAME_START_FLAG = flag_q;
	assign MULTIFRAME_START_IRQ  = flag_q & ~MF_IRQ_MASK;
	assign LINK_RX_OUT           = link_out_q;

	// ==========================================
	// Transmit time slot zero
	logic [7:0] ts0_d;
	logic [7:0] ts0_q;
	logic       vld_q;
	logic       vld_d;
	logic       ones_q;
	logic       ones_d;
	logic       bit1;
	logic       sa;

	always_comb begin
		ts0_d = ts0_q;
		bit1  = 1'b0;
		sa    = 1'b0;
		if (!tx_frm_d[0]) begin
			bit1  = TX_CRC[3 - tx_frm_d[2:1]];
			ts0_d = {bit1, `E1TS_FAS_PAT};
		end else begin
			if (tx_frm_d == 4'hD) begin
				bit1 = TX_EBIT[1];
			end else if (tx_frm_d == 4'hF) begin
				bit1 = TX_EBIT[0];
			end else begin
				bit1 = MFAS_PAT[3'h5 - tx_frm_d[3:1]];
			end
			ts0_d = {bit1, 1'b1, REMOTE_ALARM_BIT, 5'h00};
			for (int s = 0; s < NBYTES; s++) begin
				if (LINK_EN && LINK_SEL[s]) begin
					sa = link_tx_q;
				end else if (!cpu_ok) begin
					sa = CONTROL_STREAM_IN_ZERO[4 - s];
				end else begin
					sa = tx_buf_q[s][col_of(tx_frm_d)];
				end
				ts0_d[4 - s] = sa;
			end
		end
		if (!FORCE_ALL_ONES_PIN_B) begin
			ts0_d = `E1TS_ALL_ONES;
		end
		// The word only moves on a frame tick, so it stands for a whole frame
		if (!tick) begin
			ts0_d = ts0_q;
		end
		vld_d  = tick;
		ones_d = ~FORCE_ALL_ONES_PIN_B;
	end

	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			ts0_q  <= `E1TS_ALL_ONES;
			vld_q  <= 1'b0;
			ones_q <= 1'b1;
		end else begin
			ts0_q  <= ts0_d;
			vld_q  <= vld_d;
			ones_q <= ones_d;
		end
	end

	assign TX_TS0      = ts0_q;
	assign TX_TS0_VLD  = vld_q;
	assign TX_ALL_ONES = ones_q;

	// ==========================================
	// Checks
	sequence tick_even_s;
		tick && FORCE_ALL_ONES_PIN_B && !tx_frm_d[0];
	endsequence

	sequence tick_odd_s;
		tick && FORCE_ALL_ONES_PIN_B && tx_frm_d[0];
	endsequence

	all_ones_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		tick && !FORCE_ALL_ONES_PIN_B |=> TX_TS0 == 8'hFF && TX_TS0_VLD)
		else $error("all ones not sent while forced");
	fas_word_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		tick_even_s |=> TX_TS0[6:0] == 7'h1B)
		else $error("alignment pattern wrong");
	nfas_bit2_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		tick_odd_s |=> TX_TS0[6] && TX_TS0[5] == $past(REMOTE_ALARM_BIT))
		else $error("non-alignment word wrong");
	mfas_seq_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		tick_odd_s ##0 (tx_frm_d == 4'h5) |=> TX_TS0[7])
		else $error("multiframe pattern wrong in frame 5");
	crc_pos_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		tick_even_s ##0 (tx_frm_d == 4'h8) |=> TX_TS0[7] == $past(TX_CRC[3]))
		else $error("C1 missing from frame 8");
	mf_flag_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		mf_start |=> MULTIFRAME_START_FLAG ##0 (MULTIFRAME_START_IRQ == !MF_IRQ_MASK))
		else $error("multiframe flag not raised");
	link_clk_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		tick |=> LINK_CLOCK_OUT != $past(LINK_CLOCK_OUT))
		else $error("link clock did not toggle on frame");
	link_rx_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		$rose(LINK_CLOCK_OUT) |-> LINK_RX_OUT == $past(link_rxb_q))
		else $error("link data not aligned with clock");
	bp_lock_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		!cpu_ok && CPU_REQ.wr |=> $stable(tx_buf_q[0]) && $stable(tx_buf_q[4]))
		else $error("buffer written in backplane mode");
	link_src_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		tick_odd_s ##0 (LINK_EN && $onehot(LINK_SEL))
		|=> pick_sa(TX_TS0, $past(LINK_SEL)) == $past(link_tx_q))
		else $error("link bit not taken from link input");
	all_ones_lvl_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		!FORCE_ALL_ONES_PIN_B |=> TX_ALL_ONES)
		else $error("all-ones indication missing");
	flag_clear_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		MF_FLAG_CLR && !mf_start |=> !MULTIFRAME_START_FLAG)
		else $error("multiframe flag not cleared");
	rx_refresh_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		mf_start |=> rx_buf_q[0] == $past(stage_q[0]) && rx_buf_q[4] == $past(stage_q[4]))
		else $error("receive buffer not refreshed at multiframe start");
	link_smp_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		sample_rise |=> link_tx_q == $past(LINK_TX_IN) && !LINK_CLOCK_OUT)
		else $error("link input not sampled at clock midpoint");
endmodule : e1ts_top

/* sim/e1ts_hdlc_model.sv */
`timescale 1ns/1ns
// ==========
// Link controller model
module e1ts_hdlc_model (
	input  wire logic LINK_CLOCK_OUT,
	input  wire logic LINK_RX_OUT,
	input  wire logic send_bit,
	output logic      LINK_TX_IN,
	output logic      rx_bit
);
	initial LINK_TX_IN = 1'b1;
	initial rx_bit = 1'b1;
	// Change just after the rising edge so data is steady at the mid-cycle sample
	always @(posedge LINK_CLOCK_OUT) begin
		LINK_TX_IN <= send_bit;
	end
	// Received data moves with the rising edge, so take it on the falling one
	always @(negedge LINK_CLOCK_OUT) begin
		rx_bit <= LINK_RX_OUT;
	end
endmodule : e1ts_hdlc_model

/* sim/test_e1ts_top.sv */
`timescale 1ns/1ns
// ==========
// Bench
module test_e1ts_top;
	localparam int FC = 20;
	logic                      clk, rst_b, force_b, stb, clr, mask, link_en, send_bit;
	logic                      vld, all1, flag, irq, ltx, lrx, lclk, rx_bit, alarm, mon;
	logic [7:0]                rdata, ts0, rx_ts0, cs_in, status, e;
	logic [3:0]                crc, frm;
	logic [1:0]                ebit;
	logic [4:0]                sel;
	logic [7:0]                txb [5];
	e1ts_pkg::e1ts_port_mode_t mode;
	e1ts_pkg::e1ts_cpu_req_t   req;
	int                        failures, total_checks, fcnt;
	time                       t0;

	e1ts_top #(.FRAME_CYC(FC), .NBYTES(5)) u_dut (.CORE_CLK(clk), .RST_B(rst_b),
		.FORCE_ALL_ONES_PIN_B(force_b), .PORT_MODE(mode), .CPU_REQ(req), .CPU_RDATA(rdata),
		.TX_CRC(crc), .TX_EBIT(ebit), .REMOTE_ALARM_BIT(alarm), .CONTROL_STREAM_IN_ZERO(cs_in),
		.TX_TS0(ts0), .TX_TS0_VLD(vld), .TX_ALL_ONES(all1), .RX_TS0_STB(stb), .RX_TS0(rx_ts0),
		.RX_FRM_NUM(frm), .STATUS_STREAM_OUT(status), .MF_FLAG_CLR(clr), .MF_IRQ_MASK(mask),
		.MULTIFRAME_START_FLAG(flag), .MULTIFRAME_START_IRQ(irq), .LINK_EN(link_en),
		.LINK_SEL(sel), .LINK_TX_IN(ltx), .LINK_RX_OUT(lrx), .LINK_CLOCK_OUT(lclk));
	e1ts_hdlc_model u_link (.LINK_CLOCK_OUT(lclk), .LINK_RX_OUT(lrx), .send_bit(send_bit),
		.LINK_TX_IN(ltx), .rx_bit(rx_bit));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic results();
		$display("Checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : results

	task automatic wr(logic rx, logic [2:0] a, logic [7:0] d);
		@(negedge clk) req = '{1'b1, 1'b0, rx, a, d};
		@(negedge clk) req = '0;
	endtask : wr

	task automatic rdc(logic rx, logic [2:0] a, logic [7:0] exp, string nm);
		@(negedge clk) req = '{1'b0, 1'b1, rx, a, 8'h00};
		@(negedge clk) req = '0;
		@(negedge clk) chk(nm, exp, rdata);
	endtask : rdc

	task automatic rxf(logic [3:0] f, logic [7:0] b);
		@(negedge clk) {stb, frm, rx_ts0} = {1'b1, f, b};
		@(negedge clk) stb = 1'b0;
	endtask : rxf

	function automatic logic [7:0] exp_ts0(int f);
		logic [7:0] x;
		logic [5:0] mf = 6'h0B;
		if (!force_b) return 8'hFF;
		if (f % 2 == 0) return {crc[3 - (f / 2) % 4], 7'h1B};
		x[7] = (f < 12) ? mf[5 - f / 2] : (f == 13 ? ebit[1] : ebit[0]);
		x[6:5] = {1'b1, alarm};
		for (int n = 0; n < 5; n++)
			x[4 - n] = (mode == e1ts_pkg::E1TS_BACKPLANE) ? cs_in[4 - n] :
				(link_en && sel[n]) ? send_bit : txb[n][7 - f / 2];
		return x;
	endfunction : exp_ts0

	// Frame numbering is counted here from the first word after reset
	always @(negedge clk) if (vld) begin
		fcnt = fcnt + 1;
		if (mon) chk("ts0", exp_ts0(fcnt % 16), ts0);
	end

	initial begin
		#(200 * FC * 40);
		failures++;
		results();
	end

	initial begin
		{rst_b, force_b, stb, clr, mask, link_en, send_bit, frm, rx_ts0} = '0;
		{crc, ebit, alarm, cs_in, sel, mon} = {4'hA, 2'b10, 1'b1, 8'h15, 5'h04, 1'b1};
		{failures, total_checks, fcnt} = '0;
		mode = e1ts_pkg::E1TS_PARALLEL;
		req = '0;
		foreach (txb[i]) txb[i] = 8'hFF;
		repeat (12) @(negedge clk);
		rst_b = 1'b1;
		repeat (3 * FC) @(negedge clk);
		chk("all_ones", 8'h01, {7'h00, all1});
		$display("Test all-ones done");
		mon = 1'b0;
		force_b = 1'b1;
		for (int n = 0; n < 5; n++) begin
			txb[n] = 8'(8'h9C + n * 8'h13);
			wr(1'b0, 3'(n), txb[n]);
		end
		for (int n = 0; n < 5; n++) rdc(1'b0, 3'(n), txb[n], "txbuf");
		rdc(1'b0, 3'h5, 8'h00, "unmapped");
		wr(1'b1, 3'h0, 8'h00);
		rdc(1'b1, 3'h0, 8'hFF, "rx_ro");
		mode = e1ts_pkg::E1TS_BACKPLANE;
		wr(1'b0, 3'h0, 8'h00);
		rdc(1'b0, 3'h0, 8'h00, "bp_rd");
		mode = e1ts_pkg::E1TS_SERIAL_CTRL;
		rdc(1'b0, 3'h0, txb[0], "sc_rd");
		mode = e1ts_pkg::E1TS_PARALLEL;
		repeat (2 * FC) @(negedge clk);
		mon = 1'b1;
		repeat (32 * FC) @(negedge clk);
		mon = 1'b0;
		mode = e1ts_pkg::E1TS_BACKPLANE;
		repeat (2 * FC) @(negedge clk);
		mon = 1'b1;
		repeat (16 * FC) @(negedge clk);
		{mon, link_en} = 2'b01;
		mode = e1ts_pkg::E1TS_PARALLEL;
		repeat (6 * FC) @(negedge clk);
		mon = 1'b1;
		repeat (16 * FC) @(negedge clk);
		// Link input needs a few frames to pass through the partner and the sampler
		{mon, send_bit} = 2'b01;
		repeat (6 * FC) @(negedge clk);
		mon = 1'b1;
		repeat (16 * FC) @(negedge clk);
		mon = 1'b0;
		chk("all_ones_off", 8'h00, {7'h00, all1});
		$display("Test transmit done");
		for (int f = 1; f < 16; f += 2) rxf(4'(f), {3'b010, 5'(f)});
		rdc(1'b1, 3'h0, 8'hFF, "rx_hold");
		chk("status", 8'h4F, status);
		chk("flag_idle", 8'h00, {7'h00, flag});
		rxf(4'h0, 8'h1B);
		chk("flag", 8'h03, {6'h00, flag, irq});
		@(negedge clk) mask = 1'b1;
		@(negedge clk) chk("masked", 8'h02, {6'h00, flag, irq});
		clr = 1'b1;
		@(negedge clk) clr = 1'b0;
		chk("cleared", 8'h00, {7'h00, flag});
		for (int n = 0; n < 5; n++) begin
			for (int c = 0; c < 8; c++) e[7 - c] = 1'(5'(2 * c + 1) >> (4 - n));
			rdc(1'b1, 3'(n), e, "rxbuf");
		end
		rxf(4'h9, 8'h40);
		repeat (6 * FC) @(negedge clk);
		chk("link_rx0", 8'h00, {7'h00, rx_bit});
		rxf(4'h9, 8'h5F);
		repeat (6 * FC) @(negedge clk);
		chk("link_rx1", 8'h01, {7'h00, rx_bit});
		@(posedge lclk) t0 = $time;
		@(posedge lclk) chk("link_clock_out_per", 8'(2 * FC), 8'(($time - t0) / 40));
		$display("Test receive and link done");
		results();
	end
endmodule : test_e1ts_top
